// *** rtl/prc_ratio_cfg.sv ***
// What this block does
// RULE1 - the timing reference is divided by a factor picked by a two-bit global setting, which the configurer keeps in range.
// RULE2 - four 32-bit unsigned ratios are stored and the mode-select pins pick the one in use.
// RULE3 - in high-resolution format a ratio is 12 integer bits over 20 fraction bits.
// RULE4 - in high-multiplication format a ratio is 20 integer bits over 12 fraction bits.
// RULE5 - one global format bit decides how every stored ratio is read.
// RULE6 - modifier codes 00, 01, 10, 11 scale the ratio by one half, quarter, eighth, sixteenth.
// RULE7 - the modifier alters only the ratio used inside; stored ratios never change.
// RULE8 - the modifier acts only when the special pin is configured for it and enables it.
// RULE9 - with the special-pin setting at 011 a high pin enables the modifier and a low pin disables it.
// RULE10 - effective ratio is the selected ratio times the modifier, or times one when disabled.
// RULE11 - the reference divider is compensated inside, so ratios express output over input only.
// RULE12 - the configurer avoids modifiers that overflow or truncate and keeps the ratio in range.
// RULE13 - the loop measures the reference input against the timing clock and derives the fractional-N value.
// RULE14 - a three-bit global setting picks minimum loop bandwidth from 1 Hz to 128 Hz.
// RULE15 - while acquiring lock the bandwidth is forced wide, then settles to the selected minimum.
// RULE16 - any change on the mode-select pins drops lock while the new ratio takes effect.
// RULE17 - the modifier is applied as a right shift of one to four places in the same format.
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
module prc_ratio_cfg #(
    parameter int PERIOD_W = 24
) (
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic [5:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    input wire logic [1:0] MODE_SELECT_PINS,
    input wire logic SPECIAL_FUNCTION_PIN,
    input wire logic FREQ_REFERENCE_PIN,
    output logic DIVIDED_TIMING_TICK,
    output logic [31:0] EFFECTIVE_RATIO,
    output logic [39:0] FRACN_VALUE,
    output logic FRACN_UPDATE,
    output logic PLL_LOCKED,
    output logic WIDE_BANDWIDTH
);
    initial begin
        if (PERIOD_W < 4 || PERIOD_W > 32) begin
            $error("prc_ratio_cfg: PERIOD_W must be 4 to 32");
        end
    end

    // configuration storage
    logic [31:0] global_cfg_reg;
    logic [31:0] modal_cfg_reg;
    logic [31:0] stored_ratio_set [4];

    logic [1:0] timing_reference_clock_divide_select;
    logic ratio_format_select;
    logic [2:0] special_pin_function_config;
    logic [2:0] min_loop_bandwidth_select;

    assign timing_reference_clock_divide_select = global_cfg_reg[prc_pkg::GCFG_DIV_LSB +: 2];
    assign ratio_format_select = global_cfg_reg[prc_pkg::GCFG_FMT_BIT];
    assign special_pin_function_config = global_cfg_reg[prc_pkg::GCFG_SPC_LSB +: 3];
    assign min_loop_bandwidth_select = global_cfg_reg[prc_pkg::GCFG_BW_LSB +: 3];

    // pin synchronisers; first stage is read by the second only
    logic [3:0] pin_meta_reg;
    logic [3:0] pin_sync_reg;
    logic [1:0] mode_sync;
    logic special_function_pin;
    logic ref_sync;

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pin_meta_reg <= 4'h0;
            pin_sync_reg <= 4'h0;
        end else begin
            pin_meta_reg <= {FREQ_REFERENCE_PIN, SPECIAL_FUNCTION_PIN, MODE_SELECT_PINS};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign mode_sync = pin_sync_reg[1:0];
    assign special_function_pin = pin_sync_reg[2];
    assign ref_sync = pin_sync_reg[3];

    // register writes
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            global_cfg_reg <= prc_pkg::RST_GLOBAL_CFG;
            modal_cfg_reg <= prc_pkg::RST_MODAL_CFG;
        end else if (REG_WR) begin
            if (REG_ADDR == prc_pkg::OFS_GLOBAL_CFG) begin
                global_cfg_reg <= REG_WDATA & prc_pkg::GCFG_WRITE_MASK;
            end
            if (REG_ADDR == prc_pkg::OFS_MODAL_CFG) begin
                modal_cfg_reg <= {24'h00_0000, REG_WDATA[7:0]};
            end
        end
    end

    // RULE7 ratio store
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            for (int i = 0; i < 4; i++) begin
                stored_ratio_set[i] <= prc_pkg::RST_RATIO;
            end
        end else if (REG_WR) begin
            for (int i = 0; i < 4; i++) begin
                if (REG_ADDR == prc_pkg::OFS_RATIO0 + 6'(4 * i)) begin
                    stored_ratio_set[i] <= REG_WDATA;
                end
            end
        end
    end

    // RULE1 timing reference divider
    logic [2:0] div_cnt_reg;
    logic [2:0] div_limit;
    logic div_tick;

    assign div_limit = 3'((4'h1 << timing_reference_clock_divide_select) - 4'h1);
    assign div_tick = div_cnt_reg >= div_limit;

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            div_cnt_reg <= 3'h0;
        end else begin
            div_cnt_reg <= div_tick ? 3'h0 : div_cnt_reg + 3'h1;
        end
    end

    assign DIVIDED_TIMING_TICK = div_tick;

    // RULE2 ratio selection by mode pins
    logic [31:0] user_ratio;
    logic [1:0] ratio_modifier_select;
    logic rmod_enable;

    assign user_ratio = stored_ratio_set[mode_sync];
    assign ratio_modifier_select = modal_cfg_reg[2 * mode_sync +: 2];

    // RULE8 RULE9 modifier gate
    assign rmod_enable = special_pin_function_config == prc_pkg::SPC_RMOD_ENABLE
        && special_function_pin;

    // RULE6 RULE10 RULE17 power-of-two modifier as shift
    logic [31:0] effective_ratio;
    always_comb begin
        effective_ratio = user_ratio;
        if (rmod_enable) begin
            effective_ratio = user_ratio >> (3'h1 + {1'b0, ratio_modifier_select});
        end
    end

    // RULE3 RULE4 RULE5 normalise to 20.20 for the loop
    logic [39:0] norm_ratio;
    assign norm_ratio = (ratio_format_select == prc_pkg::FMT_HIGH_MULT)
        ? {effective_ratio, 8'h00}
        : {8'h00, effective_ratio};

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            EFFECTIVE_RATIO <= 32'h0000_0000;
        end else begin
            EFFECTIVE_RATIO <= effective_ratio;
        end
    end

    // RULE13 reference period in divided timing ticks
    logic ref_d_reg;
    logic ref_rise;
    logic [PERIOD_W-1:0] period_cnt_reg;
    logic [PERIOD_W-1:0] period_reg;
    logic period_seen_reg;
    logic period_sat;
    logic ref_lost_reg;

    assign ref_rise = ref_sync && !ref_d_reg;
    assign period_sat = &period_cnt_reg;

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ref_d_reg <= 1'b0;
            period_cnt_reg <= '0;
            period_reg <= '0;
            period_seen_reg <= 1'b0;
            ref_lost_reg <= 1'b0;
        end else begin
            ref_d_reg <= ref_sync;
            ref_lost_reg <= 1'b0;
            if (ref_rise) begin
                // tick in the rise cycle belongs to the new period
                period_cnt_reg <= div_tick ? PERIOD_W'(1) : '0;
                period_reg <= period_cnt_reg;
                period_seen_reg <= 1'b1;
            end else if (period_sat) begin
                // reference stopped; drop lock and wait for a fresh first edge
                period_cnt_reg <= '0;
                period_seen_reg <= 1'b0;
                ref_lost_reg <= period_seen_reg;
            end else if (div_tick) begin
                period_cnt_reg <= period_cnt_reg + PERIOD_W'(1);
            end
        end
    end

    // RULE11 counting divided ticks folds the divider into the result
    logic div_start;
    logic div_done;
    logic [39:0] n_target;

    assign div_start = ref_rise && period_seen_reg && period_cnt_reg != '0;

    prc_serial_div #(
        .DIVIDEND_W(40),
        .DIVISOR_W(PERIOD_W)
    ) u_div (
        .clk(MCLK),
        .rst_n(ARST_N),
        .start(div_start),
        .dividend(norm_ratio),
        .divisor(period_cnt_reg),
        .busy(),
        .done(div_done),
        .quotient(n_target)
    );

    // RULE16 mode change and modifier enable change force reacquisition
    logic [1:0] mode_prev_reg;
    logic rmod_prev_reg;
    logic restart;

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            mode_prev_reg <= 2'h0;
            rmod_prev_reg <= 1'b0;
        end else begin
            mode_prev_reg <= mode_sync;
            rmod_prev_reg <= rmod_enable;
        end
    end

    assign restart = mode_sync != mode_prev_reg || rmod_enable != rmod_prev_reg
        || ref_lost_reg;

    // RULE14 bandwidth select, 1 Hz narrowest shift, 128 Hz widest
    logic [3:0] bw_shift;
    assign bw_shift = prc_pkg::BW_SHIFT_MAX - {1'b0, min_loop_bandwidth_select};

    prc_pkg::prc_state_t state_reg;
    prc_pkg::prc_state_t state_next;
    logic settled;

    prc_loop_filter #(
        .VAL_W(40)
    ) u_filter (
        .clk(MCLK),
        .rst_n(ARST_N),
        .restart(restart),
        .target(n_target),
        .target_valid(div_done),
        .wide(state_reg == prc_pkg::ST_ACQUIRE),
        .bw_shift(bw_shift),
        .n_value(FRACN_VALUE),
        .n_update(FRACN_UPDATE),
        .settled(settled)
    );

    // RULE15 lock state: wide until settled
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            prc_pkg::ST_ACQUIRE: begin
                if (settled && !restart) begin
                    state_next = prc_pkg::ST_LOCKED;
                end
            end
            prc_pkg::ST_LOCKED: begin
                if (restart || !settled) begin
                    state_next = prc_pkg::ST_ACQUIRE;
                end
            end
            default: begin
                state_next = prc_pkg::ST_ACQUIRE;
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_reg <= prc_pkg::ST_ACQUIRE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign PLL_LOCKED = state_reg == prc_pkg::ST_LOCKED;
    assign WIDE_BANDWIDTH = state_reg == prc_pkg::ST_ACQUIRE;

    // register reads, data one cycle after the strobe
    logic [31:0] status_word;
    logic [31:0] read_mux;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[prc_pkg::STAT_LOCK_BIT] = PLL_LOCKED;
        status_word[prc_pkg::STAT_WIDE_BIT] = WIDE_BANDWIDTH;
        status_word[prc_pkg::STAT_RMOD_BIT] = rmod_enable;
        status_word[prc_pkg::STAT_MODE_LSB +: 2] = mode_sync;
    end

    always_comb begin
        unique case (REG_ADDR)
            prc_pkg::OFS_GLOBAL_CFG: read_mux = global_cfg_reg;
            prc_pkg::OFS_MODAL_CFG: read_mux = modal_cfg_reg;
            prc_pkg::OFS_RATIO0: read_mux = stored_ratio_set[0];
            prc_pkg::OFS_RATIO1: read_mux = stored_ratio_set[1];
            prc_pkg::OFS_RATIO2: read_mux = stored_ratio_set[2];
            prc_pkg::OFS_RATIO3: read_mux = stored_ratio_set[3];
            prc_pkg::OFS_STATUS: read_mux = status_word;
            prc_pkg::OFS_EFF_RATIO: read_mux = EFFECTIVE_RATIO;
            prc_pkg::OFS_FRACN_LO: read_mux = FRACN_VALUE[31:0];
            prc_pkg::OFS_FRACN_HI: read_mux = {24'h00_0000, FRACN_VALUE[39:32]};
            prc_pkg::OFS_REF_PERIOD: read_mux = 32'(period_reg);
            default: read_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            REG_RDATA <= 32'h0000_0000;
        end else if (REG_RD) begin
            REG_RDATA <= read_mux;
        end else begin
            REG_RDATA <= 32'h0000_0000;
        end
    end
endmodule // prc_ratio_cfg

// *** rtl/prc_pkg.sv ***
package prc_pkg;

    // register byte offsets, one aligned word each
    localparam logic [5:0] OFS_GLOBAL_CFG = 6'h00;
    localparam logic [5:0] OFS_MODAL_CFG = 6'h04;
    localparam logic [5:0] OFS_RATIO0 = 6'h08;
    localparam logic [5:0] OFS_RATIO1 = 6'h0C;
    localparam logic [5:0] OFS_RATIO2 = 6'h10;
    localparam logic [5:0] OFS_RATIO3 = 6'h14;
    localparam logic [5:0] OFS_STATUS = 6'h18;
    localparam logic [5:0] OFS_EFF_RATIO = 6'h1C;
    localparam logic [5:0] OFS_FRACN_LO = 6'h20;
    localparam logic [5:0] OFS_FRACN_HI = 6'h24;
    localparam logic [5:0] OFS_REF_PERIOD = 6'h28;

    // global configuration fields
    localparam int GCFG_DIV_LSB = 0;
    localparam int GCFG_FMT_BIT = 2;
    localparam int GCFG_SPC_LSB = 4;
    localparam int GCFG_BW_LSB = 8;
    localparam logic [31:0] GCFG_WRITE_MASK = 32'h0000_0777;

    // status fields
    localparam int STAT_LOCK_BIT = 0;
    localparam int STAT_WIDE_BIT = 1;
    localparam int STAT_RMOD_BIT = 2;
    localparam int STAT_MODE_LSB = 4;

    // values after reset
    localparam logic [31:0] RST_GLOBAL_CFG = 32'h0000_0000;
    localparam logic [31:0] RST_MODAL_CFG = 32'h0000_0000;
    localparam logic [31:0] RST_RATIO = 32'h0010_0000;

    // encodings
    localparam logic [2:0] SPC_RMOD_ENABLE = 3'h3;
    localparam logic FMT_HIGH_MULT = 1'b1;

    // fixed-point layout
    localparam int RATIO_W = 32;
    localparam int NORM_W = 40;
    localparam int NORM_PAD = 8;

    // loop behaviour
    localparam logic [3:0] ACQ_SHIFT = 4'h1;
    localparam logic [3:0] BW_SHIFT_MAX = 4'h8;
    localparam logic [39:0] LOCK_TOL = 40'h00_0000_1000;
    localparam logic [7:0] LOCK_HOLD_COUNT = 8'h10;

    typedef enum logic [1:0] {
        ST_ACQUIRE = 2'b01,
        ST_LOCKED = 2'b10
    } prc_state_t;

endpackage

// *** rtl/prc_serial_div.sv ***
`timescale 1ns/1ns
module prc_serial_div #(
    parameter int DIVIDEND_W = 40,
    parameter int DIVISOR_W = 24
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [DIVIDEND_W-1:0] dividend,
    input wire logic [DIVISOR_W-1:0] divisor,
    output logic busy,
    output logic done,
    output logic [DIVIDEND_W-1:0] quotient
);
    localparam int CNT_W = $clog2(DIVIDEND_W + 1);

    initial begin
        if (DIVIDEND_W < 2 || DIVISOR_W < 1 || DIVISOR_W > DIVIDEND_W) begin
            $error("prc_serial_div: unsupported widths");
        end
    end

    logic [CNT_W-1:0] cnt_reg;
    logic [DIVIDEND_W-1:0] quo_reg;
    logic [DIVISOR_W-1:0] dsr_reg;
    logic [DIVISOR_W:0] rem_reg;
    logic [DIVISOR_W:0] rem_shift;
    logic rem_ge;

    assign rem_shift = {rem_reg[DIVISOR_W-1:0], quo_reg[DIVIDEND_W-1]};
    assign rem_ge = rem_shift >= {1'b0, dsr_reg};

    // one quotient bit per cycle; start while busy is ignored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            cnt_reg <= '0;
            quo_reg <= '0;
            dsr_reg <= '0;
            rem_reg <= '0;
        end else if (!busy) begin
            if (start) begin
                busy <= 1'b1;
                cnt_reg <= CNT_W'(DIVIDEND_W);
                quo_reg <= dividend;
                dsr_reg <= divisor;
                rem_reg <= '0;
            end
        end else begin
            rem_reg <= rem_ge ? rem_shift - {1'b0, dsr_reg} : rem_shift;
            quo_reg <= {quo_reg[DIVIDEND_W-2:0], rem_ge};
            cnt_reg <= cnt_reg - CNT_W'(1);
            if (cnt_reg == CNT_W'(1)) begin
                busy <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done <= 1'b0;
            quotient <= '0;
        end else begin
            done <= busy && cnt_reg == CNT_W'(1);
            if (busy && cnt_reg == CNT_W'(1)) begin
                quotient <= {quo_reg[DIVIDEND_W-2:0], rem_ge};
            end
        end
    end
endmodule // prc_serial_div

// *** rtl/prc_loop_filter.sv ***
`timescale 1ns/1ns
module prc_loop_filter #(
    parameter int VAL_W = 40
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic restart,
    input wire logic [VAL_W-1:0] target,
    input wire logic target_valid,
    input wire logic wide,
    input wire logic [3:0] bw_shift,
    output logic [VAL_W-1:0] n_value,
    output logic n_update,
    output logic settled
);
    initial begin
        if (VAL_W != 40) begin
            $error("prc_loop_filter: value width must match lock tolerance");
        end
    end

    logic primed_reg;
    logic [7:0] hold_reg;
    logic signed [VAL_W:0] diff;
    logic signed [VAL_W:0] step;
    logic [VAL_W:0] abs_diff;
    logic [3:0] shift_use;
    logic in_tol;

    assign diff = $signed({1'b0, target}) - $signed({1'b0, n_value});
    // wide bandwidth while acquiring, narrow once locked
    assign shift_use = wide ? prc_pkg::ACQ_SHIFT : bw_shift;
    assign step = diff >>> shift_use;
    assign abs_diff = diff[VAL_W] ? (VAL_W+1)'(-diff) : diff;
    assign in_tol = abs_diff <= {1'b0, prc_pkg::LOCK_TOL};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            n_value <= '0;
            primed_reg <= 1'b0;
        end else if (restart) begin
            primed_reg <= 1'b0;
        end else if (target_valid) begin
            primed_reg <= 1'b1;
            // first estimate after a restart is taken whole for fast pull-in
            n_value <= primed_reg ? n_value + step[VAL_W-1:0] : target;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_reg <= '0;
            settled <= 1'b0;
        end else if (restart) begin
            hold_reg <= '0;
            settled <= 1'b0;
        end else if (target_valid && primed_reg) begin
            if (!in_tol) begin
                hold_reg <= '0;
                settled <= 1'b0;
            end else if (hold_reg == prc_pkg::LOCK_HOLD_COUNT) begin
                settled <= 1'b1;
            end else begin
                hold_reg <= hold_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            n_update <= 1'b0;
        end else begin
            n_update <= target_valid && !restart;
        end
    end
endmodule // prc_loop_filter

// *** verif/prc_ratio_cfg_properties.sv ***
`timescale 1ns/1ns
module prc_ratio_cfg_chk #(
    parameter int PERIOD_W = 24
) (
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic [5:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [31:0] REG_RDATA,
    input wire logic [1:0] MODE_SELECT_PINS,
    input wire logic SPECIAL_FUNCTION_PIN,
    input wire logic DIVIDED_TIMING_TICK,
    input wire logic [31:0] EFFECTIVE_RATIO,
    input wire logic FRACN_UPDATE,
    input wire logic PLL_LOCKED,
    input wire logic WIDE_BANDWIDTH
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!ARST_N);
    logic [1:0] div_reg;
    // shadow of the divide field, seen only through bus writes
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            div_reg <= 2'h0;
        end else if (REG_WR && REG_ADDR == prc_pkg::OFS_GLOBAL_CFG) begin
            div_reg <= REG_WDATA[1:0];
        end
    end
    property p_tick_div1;
        div_reg == 2'h0 |-> DIVIDED_TIMING_TICK;
    endproperty
    a_tick_div1: assert property (p_tick_div1)
        else $error("tick missing at divide by one");
    property p_tick_gap;
        div_reg != 2'h0 && $stable(div_reg) && DIVIDED_TIMING_TICK
            |=> !DIVIDED_TIMING_TICK || $changed(div_reg);
    endproperty
    a_tick_gap: assert property (p_tick_gap)
        else $error("tick repeated while dividing");
    property p_wide;
        WIDE_BANDWIDTH == !PLL_LOCKED;
    endproperty
    a_wide: assert property (p_wide)
        else $error("bandwidth not wide while unlocked");
    property p_lock_rise;
        $rose(PLL_LOCKED) |-> FRACN_UPDATE || $past(FRACN_UPDATE)
            || $past(FRACN_UPDATE, 2);
    endproperty
    a_lock_rise: assert property (p_lock_rise)
        else $error("lock rose without a loop update");
    property p_mode_unlock;
        $changed(MODE_SELECT_PINS) |-> ##[1:4] !PLL_LOCKED;
    endproperty
    a_mode_unlock: assert property (p_mode_unlock)
        else $error("lock kept over a mode change");
    property p_upd_pulse;
        FRACN_UPDATE |=> !FRACN_UPDATE [*8];
    endproperty
    a_upd_pulse: assert property (p_upd_pulse)
        else $error("update pulses too close");
    property p_eff_stable;
        ($stable(MODE_SELECT_PINS) && $stable(SPECIAL_FUNCTION_PIN) && !REG_WR) [*4]
            |=> $stable(EFFECTIVE_RATIO);
    endproperty
    a_eff_stable: assert property (p_eff_stable)
        else $error("effective ratio moved with no cause");
    property p_rd_idle;
        !REG_RD |=> REG_RDATA == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read slot");
    property p_status;
        REG_RD && REG_ADDR == prc_pkg::OFS_STATUS
            |=> REG_RDATA[1:0] == {$past(WIDE_BANDWIDTH), $past(PLL_LOCKED)};
    endproperty
    a_status: assert property (p_status)
        else $error("status disagrees with lock pins");
endmodule // prc_ratio_cfg_chk

bind prc_ratio_cfg prc_ratio_cfg_chk #(.PERIOD_W(PERIOD_W)) u_chk (
    .MCLK(MCLK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .MODE_SELECT_PINS(MODE_SELECT_PINS), .SPECIAL_FUNCTION_PIN(SPECIAL_FUNCTION_PIN),
    .DIVIDED_TIMING_TICK(DIVIDED_TIMING_TICK), .EFFECTIVE_RATIO(EFFECTIVE_RATIO),
    .FRACN_UPDATE(FRACN_UPDATE), .PLL_LOCKED(PLL_LOCKED), .WIDE_BANDWIDTH(WIDE_BANDWIDTH)
);

// *** verif/prc_ref_src.sv ***
`timescale 1ns/1ns
module prc_ref_src #(
    parameter int PER = 64
) (
    input wire logic clk,
    output logic ref_out
);
    int cnt = 0;
    initial ref_out = 1'b0;
    // period keeps ratio in range
    // steady period so tick counts come out exact
    always @(posedge clk) begin
        cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
        ref_out <= (cnt < PER / 2);
    end
endmodule // prc_ref_src

// *** verif/prc_ratio_cfg_tb.sv ***
`timescale 1ns/1ns
module prc_ratio_cfg_tb;
    logic MCLK = 0, ARST_N = 0, REG_WR = 0, REG_RD = 0, SPECIAL_FUNCTION_PIN = 0;
    logic [5:0] REG_ADDR = 6'h00;
    logic [31:0] REG_WDATA = 32'h0, REG_RDATA, EFFECTIVE_RATIO, d;
    logic [1:0] MODE_SELECT_PINS = 2'h0;
    logic FREQ_REFERENCE_PIN, DIVIDED_TIMING_TICK, FRACN_UPDATE, PLL_LOCKED, WIDE_BANDWIDTH;
    logic [39:0] FRACN_VALUE;
    int errors = 0, comparisons = 0;
    always #5 MCLK = ~MCLK;
    prc_ref_src #(.PER(64)) u_ref (.clk(MCLK), .ref_out(FREQ_REFERENCE_PIN));
    prc_ratio_cfg dut (.MCLK(MCLK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .MODE_SELECT_PINS(MODE_SELECT_PINS), .SPECIAL_FUNCTION_PIN(SPECIAL_FUNCTION_PIN),
        .FREQ_REFERENCE_PIN(FREQ_REFERENCE_PIN), .DIVIDED_TIMING_TICK(DIVIDED_TIMING_TICK),
        .EFFECTIVE_RATIO(EFFECTIVE_RATIO), .FRACN_VALUE(FRACN_VALUE),
        .FRACN_UPDATE(FRACN_UPDATE), .PLL_LOCKED(PLL_LOCKED), .WIDE_BANDWIDTH(WIDE_BANDWIDTH));
    task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
        comparisons++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            errors++;
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        @(posedge MCLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= v;
        @(posedge MCLK);
        REG_WR <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a);
        @(posedge MCLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge MCLK);
        REG_RD <= 1'b0;
        #1 d = REG_RDATA;
    endtask
    task automatic pins(input logic [1:0] m, input logic s);
        @(posedge MCLK);
        MODE_SELECT_PINS <= m;
        SPECIAL_FUNCTION_PIN <= s;
        repeat (6) @(posedge MCLK);
        #1;
    endtask
    // bounded so a silent loop shows as a mismatch, not a hang
    task automatic updates(input int n);
        for (int k = 0; k < 400 * n && n > 0; k++) begin
            @(posedge MCLK);
            #1 if (FRACN_UPDATE === 1'b1) n--;
        end
        chk("update count", 40'h0, 40'(n));
    endtask
    function automatic logic [31:0] rv(input int i);
        return 32'h0010_0ABC * (i + 2);
    endfunction
    task automatic t_reset;
        for (int i = 0; i < 4; i++) begin
            rd(prc_pkg::OFS_RATIO0 + 6'(4 * i));
            chk("ratio reset", {8'h0, prc_pkg::RST_RATIO}, {8'h0, d});
        end
        rd(prc_pkg::OFS_GLOBAL_CFG);
        chk("global reset", 40'h0, {8'h0, d});
        chk("eff reset", 40'h0000100000, {8'h0, EFFECTIVE_RATIO});
        chk("wide reset", 40'h1, {39'h0, WIDE_BANDWIDTH});
        $display("t_reset done");
    endtask
    task automatic t_bw;
        for (int c = 0; c < 8; c++) begin
            wr(prc_pkg::OFS_GLOBAL_CFG, {21'h0, 3'(c), 8'h00});
            rd(prc_pkg::OFS_GLOBAL_CFG);
            chk("bandwidth field", {29'h0, 3'(c), 8'h00}, {8'h0, d});
        end
        wr(prc_pkg::OFS_GLOBAL_CFG, 32'hFFFF_FFFF);
        rd(prc_pkg::OFS_GLOBAL_CFG);
        chk("global mask", {8'h0, prc_pkg::GCFG_WRITE_MASK}, {8'h0, d});
        rd(6'h3C);
        chk("unmapped read", 40'h0, {8'h0, d});
        $display("t_bw done");
    endtask
    task automatic t_mod;
        for (int i = 0; i < 4; i++) wr(prc_pkg::OFS_RATIO0 + 6'(4 * i), rv(i));
        wr(prc_pkg::OFS_MODAL_CFG, 32'h0000_00E4);
        wr(prc_pkg::OFS_GLOBAL_CFG, 32'h0000_0030);
        for (int s = 0; s < 2; s++) for (int i = 0; i < 4; i++) begin
            pins(2'(i), s[0]);
            chk("eff ratio", {8'h0, s ? rv(i) >> (i + 1) : rv(i)}, {8'h0, EFFECTIVE_RATIO});
        end
        wr(prc_pkg::OFS_EFF_RATIO, 32'h0);
        rd(prc_pkg::OFS_EFF_RATIO);
        chk("eff register", {8'h0, rv(3) >> 4}, {8'h0, d});
        wr(prc_pkg::OFS_GLOBAL_CFG, 32'h0000_0050);
        for (int i = 0; i < 4; i++) begin
            pins(2'(i), 1'b1);
            chk("eff other config", {8'h0, rv(i)}, {8'h0, EFFECTIVE_RATIO});
            rd(prc_pkg::OFS_RATIO0 + 6'(4 * i));
            chk("stored ratio", {8'h0, rv(i)}, {8'h0, d});
        end
        $display("t_mod done");
    endtask
    task automatic t_fracn(input logic [1:0] dv, input logic fm);
        logic [39:0] nrm;
        nrm = fm ? {32'h0030_0000, 8'h00} : {8'h00, 32'h0030_0000};
        for (int i = 0; i < 4; i++) wr(prc_pkg::OFS_RATIO0 + 6'(4 * i), 32'h0030_0000);
        wr(prc_pkg::OFS_GLOBAL_CFG, {29'h0, fm, dv});
        updates(2);
        pins(2'h1, 1'b0);
        pins(2'h0, 1'b0);
        updates(3);
        chk("fracn value", nrm / (40'd64 >> dv), FRACN_VALUE);
        rd(prc_pkg::OFS_REF_PERIOD);
        chk("ref period", 40'd64 >> dv, {8'h0, d});
        $display("t_fracn done");
    endtask
    task automatic t_lock;
        for (int k = 0; k < 3000 && PLL_LOCKED !== 1'b1; k++) @(posedge MCLK);
        #1 chk("locked", 40'h1, {39'h0, PLL_LOCKED});
        rd(prc_pkg::OFS_STATUS);
        chk("status", 40'h1, {38'h0, d[1:0]});
        @(posedge MCLK);
        MODE_SELECT_PINS <= 2'h2;
        repeat (5) @(posedge MCLK);
        #1 chk("unlock on mode", 40'h2, {38'h0, WIDE_BANDWIDTH, PLL_LOCKED});
        $display("t_lock done");
    endtask
    task automatic give_verdict;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge MCLK);
        ARST_N <= 1'b1;
        t_reset;
        t_bw;
        t_mod;
        t_fracn(2'h0, 1'b1);
        t_fracn(2'h3, 1'b0);
        t_fracn(2'h0, 1'b0);
        t_lock;
        give_verdict;
    end
    initial begin
        repeat (30000) @(posedge MCLK);
        errors++;
        give_verdict;
    end
endmodule // prc_ratio_cfg_tb
